// file: include/asp_pkg.sv
// constants and types shared by the asynchronous serial port
// assumes a single 50 MHz clock and synchronous active-high reset
package asp_pkg;

  // serial operating modes (mode 0 unused by this port)
  typedef enum logic [1:0] {
    ASP_MODE_NONE = 2'b00,
    ASP_MODE_1    = 2'b01,
    ASP_MODE_2    = 2'b10,
    ASP_MODE_3    = 2'b11
  } asp_mode_e;

  // bit-engine states, shared by transmit and receive
  typedef enum logic [2:0] {
    ASP_IDLE  = 3'b000,
    ASP_START = 3'b001,
    ASP_DATA  = 3'b010,
    ASP_NINTH = 3'b011,
    ASP_STOP  = 3'b100
  } asp_state_e;

  // oversampling ticks per bit
  localparam int unsigned ASP_OVERSAMPLE = 16;
  // tick at which a bit is sampled (its centre)
  localparam logic [3:0]  ASP_MID_TICK   = 4'h7;
  // index of the last data bit (eight data bits per frame)
  localparam logic [2:0]  ASP_LAST_DATA  = 3'h7;
  // default divider from mclk to 16x tick
  localparam int unsigned ASP_DIV_DEFAULT = 27;
  // reset values
  localparam logic        ASP_LINE_IDLE  = 1'b1;
  localparam logic [7:0]  ASP_BYTE_RST   = 8'h00;

endpackage : asp_pkg

// file: include/asp_tick_if.sv
// tick carrier between the rate divider and the serial port core
// assumes both ends run on mclk
`timescale 1ns/1ps
interface asp_tick_if;
  logic txTick;  // 16x tick for transmit
  logic rxTick;  // 16x tick for receive
  modport gen (output txTick, output rxTick);
  modport use_ (input txTick, input rxTick);
endinterface : asp_tick_if

// file: hw/asp_rate_div.sv
// two independent rate dividers producing one-cycle 16x tick enables
// assumes divisor inputs are held stable during frames
`timescale 1ns/1ps
module asp_rate_div
  import asp_pkg::*;
#(
  parameter int unsigned W = 16
)(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] txDiv,
  input  wire logic [W-1:0] rxDiv,
  asp_tick_if.gen           ticks
);

  logic [W-1:0] txCnt;  // transmit divider count
  logic [W-1:0] rxCnt;  // receive divider count

  // transmit divider, pulses when count reaches divisor
  always_ff @(posedge mclk)
  begin
    if (rst || txCnt >= txDiv)
      txCnt <= '0;
    else
      txCnt <= txCnt + W'(1);
  end

  // receive divider, separate so rates may differ
  always_ff @(posedge mclk)
  begin
    if (rst || rxCnt >= rxDiv)
      rxCnt <= '0;
    else
      rxCnt <= rxCnt + W'(1);
  end

  assign ticks.txTick = !rst && (txCnt >= txDiv);
  assign ticks.rxTick = !rst && (rxCnt >= rxDiv);

endmodule // asp_rate_div

// file: hw/asp_serial_port.sv
// asynchronous full-duplex serial port, modes 1 to 3, with framing check
// assumes rxPin synchronous to mclk; control bits are plain ports
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
#(
  parameter int unsigned DIV_W = 16,
  parameter logic [DIV_W-1:0] TX_DIV = DIV_W'(ASP_DIV_DEFAULT),
  parameter logic [DIV_W-1:0] RX_DIV = DIV_W'(ASP_DIV_DEFAULT)
)(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [1:0] serialMode,
  input  wire logic       rxEnable,
  input  wire logic       frameErrorEnable,
  input  wire logic       txNinthBit,
  input  wire logic [7:0] txData,
  input  wire logic       txStart,
  output logic            txBusy,
  output logic            txDoneFlag,
  input  wire logic       txDoneClear,
  output logic [7:0]      rxData,
  output logic            rxNinthBit,
  output logic            receiveDoneFlag,
  input  wire logic       receiveDoneClear,
  output logic            framingErrorFlag,
  input  wire logic       framingErrorClear,
  output logic            txPin,
  input  wire logic       rxPin
);

  asp_tick_if ticks ();

  // separate dividers give tx and rx their own rates
  asp_rate_div #(.W(DIV_W)) uDiv (
    .mclk  (mclk),
    .rst   (rst),
    .txDiv (TX_DIV),
    .rxDiv (RX_DIV),
    .ticks (ticks.gen)
  );

  logic       hasNinth;  // modes 2 and 3 carry a ninth bit
  logic       modeOn;    // one of the async modes selected

  assign modeOn   = serialMode != ASP_MODE_NONE;
  assign hasNinth = serialMode == ASP_MODE_2 || serialMode == ASP_MODE_3;

  // ---------------- transmitter ----------------
  asp_state_e txState;   // transmit state
  logic [3:0] txTickCnt; // ticks within current bit
  logic [2:0] txBitCnt;  // data bit index
  logic [7:0] txShift;   // outgoing data shift
  logic       txNinth;   // latched ninth bit
  logic       txBitEnd;  // last tick of a bit

  assign txBitEnd = ticks.txTick && txTickCnt == 4'(ASP_OVERSAMPLE - 1);
  assign txBusy   = txState != ASP_IDLE;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      txState   <= ASP_IDLE;
      txTickCnt <= 4'h0;
      txBitCnt  <= 3'h0;
      txShift   <= ASP_BYTE_RST;
      txNinth   <= 1'b0;
    end
    else
    begin
      if (ticks.txTick && txState != ASP_IDLE)
        txTickCnt <= txTickCnt + 4'h1;
      unique case (txState)
        // wait for a byte from software
        ASP_IDLE:
        begin
          txTickCnt <= 4'h0;
          if (txStart && modeOn)
          begin
            txShift  <= txData;
            // latch ninth bit from control field
            txNinth  <= txNinthBit;
            txBitCnt <= 3'h0;
            txState  <= ASP_START;
          end
        end
        ASP_START:
          if (txBitEnd)
            txState <= ASP_DATA;
        ASP_DATA:
          if (txBitEnd)
          begin
            txShift  <= {1'b0, txShift[7:1]};
            txBitCnt <= txBitCnt + 3'h1;
            if (txBitCnt == ASP_LAST_DATA)
              txState <= hasNinth ? ASP_NINTH : ASP_STOP;
          end
        ASP_NINTH:
          if (txBitEnd)
            txState <= ASP_STOP;
        ASP_STOP:
          if (txBitEnd)
            txState <= ASP_IDLE;
        default:
          txState <= ASP_IDLE;
      endcase
    end
  end

  // drive the transmit pin from a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
      txPin <= ASP_LINE_IDLE;
    else
      unique case (txState)
        ASP_START: txPin <= 1'b0;
        ASP_DATA:  txPin <= txShift[0];
        ASP_NINTH: txPin <= txNinth;
        default:   txPin <= ASP_LINE_IDLE;
      endcase
  end

  // transmit done flag, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      txDoneFlag <= 1'b0;
    else if (txState == ASP_STOP && txBitEnd)
      txDoneFlag <= 1'b1;
    else if (txDoneClear)
      txDoneFlag <= 1'b0;
  end

  // ---------------- receiver ----------------
  asp_state_e rxState;   // receive state
  logic [3:0] rxTickCnt; // ticks within current bit
  logic [2:0] rxBitCnt;  // data bit index
  logic [7:0] rxShift;   // incoming data shift
  logic       rxNinth;   // captured ninth bit
  logic       rxPrev;    // previous line level
  logic       rxMid;     // centre of bit
  logic       rxFall;    // falling edge of line
  logic       lastData;  // last data bit centre
  logic       stopMid;   // stop bit centre

  assign rxMid    = ticks.rxTick && rxTickCnt == ASP_MID_TICK;
  assign rxFall   = rxPrev && !rxPin;
  assign lastData = rxState == ASP_DATA && rxMid && rxBitCnt == ASP_LAST_DATA;
  assign stopMid  = rxState == ASP_STOP && rxMid;

  // line history for edge detection
  always_ff @(posedge mclk)
  begin
    if (rst)
      rxPrev <= ASP_LINE_IDLE;
    else
      rxPrev <= rxPin;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rxState   <= ASP_IDLE;
      rxTickCnt <= 4'h0;
      rxBitCnt  <= 3'h0;
      rxShift   <= ASP_BYTE_RST;
      rxNinth   <= 1'b0;
    end
    else
    begin
      if (ticks.rxTick && rxState != ASP_IDLE)
        rxTickCnt <= rxTickCnt + 4'h1;
      unique case (rxState)
        ASP_IDLE:
        begin
          rxTickCnt <= 4'h0;
          if (rxFall && rxEnable && modeOn)
            rxState <= ASP_START;
        end
        // false start if line high at centre
        ASP_START:
          if (rxMid)
            rxState <= rxPin ? ASP_IDLE : ASP_DATA;
        ASP_DATA:
          if (rxMid)
          begin
            rxShift  <= {rxPin, rxShift[7:1]};
            rxBitCnt <= rxBitCnt + 3'h1;
            if (rxBitCnt == ASP_LAST_DATA)
              rxState <= hasNinth ? ASP_NINTH : ASP_STOP;
          end
        ASP_NINTH:
          if (rxMid)
          begin
            rxNinth <= rxPin;
            rxState <= ASP_STOP;
          end
        // frame ends at stop centre
        ASP_STOP:
          if (rxMid)
            rxState <= ASP_IDLE;
        default:
          rxState <= ASP_IDLE;
      endcase
    end
  end

  logic rxDoneEvt;   // moment the frame is delivered
  logic lastDataEvt; // last data-type bit sampled

  // last data-type bit is the ninth bit in modes 2/3
  assign lastDataEvt = hasNinth ? (rxState == ASP_NINTH && rxMid) : lastData;
  // done at stop when checking, else at last bit
  assign rxDoneEvt = frameErrorEnable ? stopMid : lastDataEvt;

  // deliver data and ninth bit to software
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rxData     <= ASP_BYTE_RST;
      rxNinthBit <= 1'b0;
    end
    else if (rxDoneEvt)
    begin
      rxData     <= lastDataEvt && !hasNinth ? {rxPin, rxShift[7:1]} : rxShift;
      rxNinthBit <= hasNinth ? (lastDataEvt ? rxPin : rxNinth) : 1'b0;
    end
  end

  // receive done flag, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (rst)
      receiveDoneFlag <= 1'b0;
    else if (rxDoneEvt)
      receiveDoneFlag <= 1'b1;
    else if (receiveDoneClear)
      receiveDoneFlag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      framingErrorFlag <= 1'b0;
    else if (frameErrorEnable && stopMid && !rxPin)
      framingErrorFlag <= 1'b1;
    else if (framingErrorClear)
      framingErrorFlag <= 1'b0;
  end

endmodule // asp_serial_port

// file: test/asp_chk.sv
// concurrent checks on the serial port's top-level ports
// assumes bind from the bench; mclk domain only
`timescale 1ns/1ps
module asp_chk
  import asp_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [1:0] serialMode,
  input wire logic       frameErrorEnable,
  input wire logic       txStart,
  input wire logic       txBusy,
  input wire logic       txDoneFlag,
  input wire logic       receiveDoneFlag,
  input wire logic       receiveDoneClear,
  input wire logic       framingErrorFlag,
  input wire logic       framingErrorClear,
  input wire logic       txPin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // every serial bit lasts many clocks, so a fresh low holds
  sequence lowHold;
    (!txPin)[*8];
  endsequence
  rst_idle_a: assert property (disable iff (1'b0) rst |=> (txPin && !txBusy && !txDoneFlag && !receiveDoneFlag && !framingErrorFlag))
    else $error("outputs not idle after reset");
  start_take_a: assert property (txStart && !txBusy && serialMode != 2'h0 |=> txBusy)
    else $error("start not taken");
  mode_off_a: assert property (txStart && !txBusy && serialMode == 2'h0 |=> !txBusy)
    else $error("start taken while off");
  line_idle_a: assert property (!txBusy |-> txPin)
    else $error("tx line low while idle");
  bit_hold_a: assert property ($fell(txPin) |-> lowHold)
    else $error("low bit too short");
  tx_done_a: assert property ($fell(txBusy) |-> ##[0:1] txDoneFlag)
    else $error("tx done flag missing");
  fe_gate_a: assert property ($rose(framingErrorFlag) |-> $past(frameErrorEnable))
    else $error("framing flag without enable");
  fe_sticky_a: assert property (framingErrorFlag && !framingErrorClear |=> framingErrorFlag)
    else $error("framing flag dropped");
  fe_done_a: assert property ($rose(framingErrorFlag) |-> ##[0:1] receiveDoneFlag)
    else $error("done flag missing at stop");
  rd_sticky_a: assert property (receiveDoneFlag && !receiveDoneClear |=> receiveDoneFlag)
    else $error("done flag dropped");
endmodule // asp_chk

// file: test/asp_peer.sv
// remote serial peer: sends frames on its line out, captures frames on its line in
// assumes 32 mclk per bit (divider 1); drives at falling edge
`timescale 1ns/1ps
module asp_peer
  import asp_pkg::*;
#(
  parameter int BIT = 32
)(
  input wire logic mclk,
  input wire logic lineIn,
  output logic     lineOut,
  output logic     inStop
);
  initial lineOut = 1'b1;
  initial inStop = 1'b0;
  // frame order, lsb first, optional ninth bit
  task automatic send(input logic [7:0] d, input logic n9, input logic nine, input logic stopv);
    logic [10:0] f;
    f = nine ? {stopv, n9, d, 1'b0} : {1'b1, stopv, d, 1'b0};
    for (int i = 0; i < 10 + nine; i++)
    begin
      @(negedge mclk);
      lineOut = f[i];
      inStop = (i == 9 + nine);
      repeat (BIT - 1) @(negedge mclk);
    end
    // idle line is high
    @(negedge mclk);
    lineOut = 1'b1;
    inStop = 1'b0;
  endtask
  // centre-sample a frame from the device; unset bits read zero
  task automatic grab(input logic nine, output logic [10:0] f, output bit late);
    int i;
    f = 11'h0;
    for (i = 0; i < 2000 && lineIn; i++) @(negedge mclk);
    // start bit never came within the bound
    late = (i >= 2000);
    repeat (BIT / 2) @(negedge mclk);
    for (i = 0; i < 10 + nine; i++)
    begin
      f[i] = lineIn;
      repeat (BIT) @(negedge mclk);
    end
  endtask
endmodule // asp_peer

// file: test/asp_serial_port_test.sv
// self-checking bench for the serial port with a remote peer model
// assumes dividers of 1, so one bit is 32 clocks
`timescale 1ns/1ps
module asp_serial_port_test;
  import asp_pkg::*;
  logic mclk = 0, rst = 1, rxEnable = 1, frameErrorEnable = 0, txNinthBit = 0, txStart = 0;
  logic txDoneClear = 0, receiveDoneClear = 0, framingErrorClear = 0, rxPin;
  logic [1:0] serialMode = 2'h0;
  logic [7:0] txData = 8'h00, rxData, d;
  logic txBusy, txDoneFlag, rxNinthBit, receiveDoneFlag, framingErrorFlag, txPin, inStop;
  int n_errors = 0, n_checks = 0, seed = 70;
  always #10 mclk = ~mclk;
  asp_serial_port #(.TX_DIV(16'h1), .RX_DIV(16'h1)) u_asp_serial_port (.mclk, .rst, .serialMode, .rxEnable,
    .frameErrorEnable, .txNinthBit, .txData, .txStart, .txBusy, .txDoneFlag, .txDoneClear, .rxData, .rxNinthBit,
    .receiveDoneFlag, .receiveDoneClear, .framingErrorFlag, .framingErrorClear, .txPin, .rxPin);
  asp_peer u_asp_peer (.mclk, .lineIn(txPin), .lineOut(rxPin), .inStop);
  task automatic check(input logic [10:0] g, input logic [10:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // frame as the peer samples it
  function automatic logic [10:0] expFrame(input logic [7:0] b, input logic n9, input logic nine);
    return nine ? {1'b1, n9, b, 1'b0} : {2'b01, b, 1'b0};
  endfunction
  task automatic pulse(ref logic s);
    @(negedge mclk) s = 1;
    @(negedge mclk) s = 0;
  endtask
  task automatic txOne(input logic [1:0] m, input logic [7:0] b, input logic n9);
    logic [10:0] f;
    int i;
    bit late;
    serialMode = m;
    fork
      u_asp_peer.grab(m[1], f, late);
      begin
        txData = b;
        txNinthBit = n9;
        pulse(txStart);
        txData = ~b;
        pulse(txStart);
      end
    join
    check(f, expFrame(b, n9, m[1]));
    if (late)
    begin
      n_errors++;
      tally_and_finish;
    end
    for (i = 0; i < 600 && txBusy; i++) @(negedge mclk);
    if (i >= 600)
    begin
      n_errors++;
      tally_and_finish;
    end
    check(txDoneFlag, 1);
    pulse(txDoneClear);
  endtask
  task automatic rxOne(input logic [1:0] m, input logic [7:0] b, input logic n9, input logic sv, input logic fe);
    int i;
    serialMode = m;
    frameErrorEnable = fe;
    pulse(receiveDoneClear);
    fork
      u_asp_peer.send(b, n9, m[1], sv);
      begin
        for (i = 0; i < 500 && !inStop; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        check(receiveDoneFlag, !fe);
      end
    join
    repeat (4) @(negedge mclk);
    check({rxData, rxNinthBit, receiveDoneFlag}, {b, m[1] & n9, 1'b1});
    if (i >= 500)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  initial
  begin
    repeat (20) @(negedge mclk);
    rst = 0;
    check({txPin, txBusy, framingErrorFlag, receiveDoneFlag}, 4'h8);
    // mode off refuses a start
    pulse(txStart);
    check(txBusy, 0);
    for (int k = 0; k < 6; k++)
    begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      fork
        txOne(2'(1 + k % 3), d, d[0]);
        rxOne(2'(1 + k % 3), ~d, d[1], 1, k[0]);
      join
      $display("test %0d done", k);
    end
    rxOne(2'h2, 8'h5a, 1, 0, 0);
    check(framingErrorFlag, 0);
    rxOne(2'h3, 8'ha5, 0, 0, 1);
    check(framingErrorFlag, 1);
    rxOne(2'h1, 8'h3c, 0, 1, 1);
    check(framingErrorFlag, 1);
    pulse(framingErrorClear);
    check(framingErrorFlag, 0);
    $display("test framing done");
    tally_and_finish;
  end
endmodule // asp_serial_port_test
bind asp_serial_port asp_chk u_asp_chk (.mclk, .rst, .serialMode, .frameErrorEnable, .txStart, .txBusy, .txDoneFlag,
  .receiveDoneFlag, .receiveDoneClear, .framingErrorFlag, .framingErrorClear, .txPin);
